// file: pkg/dma_irq_defs.vh
// constants for the dma interrupt status and clear slice
`ifndef DMA_IRQ_DEFS_VH
`define DMA_IRQ_DEFS_VH

// channel count and bus widths
`define NUM_CHAN 8
`define ADDR_W 8
`define DATA_W 32
`define PAD_W 24

// register byte offsets
`define OFF_COMBINED_STATUS 8'h00
`define OFF_TC_MASKED_STATUS 8'h04
`define OFF_TC_CLEAR 8'h08
`define OFF_ERR_MASKED_STATUS 8'h0C
`define OFF_ERR_CLEAR 8'h10
`define OFF_TC_RAW_STATUS 8'h14
`define OFF_ERR_RAW_STATUS 8'h18
`define OFF_EVT_STATUS 8'h20
`define OFF_EVT_CLEAR 8'h24
`define OFF_EVT_ENABLE 8'h28

// reset values
`define CHAN_RESET 8'h00
`define EVT_RESET 4'h0
`define RDATA_RESET 32'h0000_0000
`define PAD_ZERO 24'h00_0000

// event register layout
`define EVT_W 4
`define EVT_TC 0
`define EVT_ERR 1
`define EVT_BAD_WRITE 2
`define EVT_RSVD_WRITE 3

`endif

// file: rtl/dma_irq_status_clear.v
// interrupt status, masked status and clear registers of an eight-channel dma controller
//
// Local design decision: the plain strobed port.
`include "dma_irq_defs.vh"

module dma_irq_status_clear (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // register port
  input wire [`ADDR_W-1:0] addr,
  input wire [`DATA_W-1:0] wr_data,
  input wire wr_en,
  input wire rd_en,
  output reg [`DATA_W-1:0] rd_data,
  // channel events from the transfer engine
  input wire [`NUM_CHAN-1:0] tc_event,
  input wire [`NUM_CHAN-1:0] err_event,
  // enable masks held elsewhere in the controller
  input wire [`NUM_CHAN-1:0] tc_irq_en,
  input wire [`NUM_CHAN-1:0] err_irq_en,
  // per-channel interrupt requests
  output reg [`NUM_CHAN-1:0] channel_irq_combined,
  output reg [`NUM_CHAN-1:0] tc_irq_masked_bit,
  output reg [`NUM_CHAN-1:0] err_irq_masked_bit,
  // summary interrupt line
  output wire irq
);

  // true when the address names a register at the given offset
  function addr_is;
    input [`ADDR_W-1:0] a;
    input [`ADDR_W-1:0] off;
    begin
      addr_is = (a == off);
    end
  endfunction

  // true for any offset that accepts a write
  function is_writable;
    input [`ADDR_W-1:0] a;
    begin
      is_writable = addr_is(a, `OFF_TC_CLEAR) || addr_is(a, `OFF_ERR_CLEAR) ||
        addr_is(a, `OFF_EVT_CLEAR) || addr_is(a, `OFF_EVT_ENABLE);
    end
  endfunction

  wire [`NUM_CHAN-1:0] tc_raw_bit;
  wire [`NUM_CHAN-1:0] err_raw_bit;
  wire [`NUM_CHAN-1:0] tc_masked_status_reg;
  wire [`NUM_CHAN-1:0] err_masked_status;
  wire [`NUM_CHAN-1:0] combined_status;
  wire [`EVT_W-1:0] evt_status;
  wire [`EVT_W-1:0] evt_enable;

  reg [`NUM_CHAN-1:0] tc_irq_clear_bit;
  reg [`NUM_CHAN-1:0] err_irq_clear_bit;
  reg [`EVT_W-1:0] evt_clr;
  reg evt_en_we;
  reg bad_write;
  reg rsvd_write;
  reg [`NUM_CHAN-1:0] rd_sel_d;
  reg [`DATA_W-1:0] rd_data_d;
  reg [`EVT_W-1:0] evt_d;

  // write decode; clear registers have no storage so they read back nothing
  always @*
  begin
    tc_irq_clear_bit = `CHAN_RESET;
    err_irq_clear_bit = `CHAN_RESET;
    evt_clr = `EVT_RESET;
    evt_en_we = 1'b0;
    bad_write = 1'b0;
    rsvd_write = 1'b0;
    if (wr_en)
    begin
      if (addr_is(addr, `OFF_TC_CLEAR))
        tc_irq_clear_bit = wr_data[`NUM_CHAN-1:0];
      else if (addr_is(addr, `OFF_ERR_CLEAR))
        err_irq_clear_bit = wr_data[`NUM_CHAN-1:0];
      else if (addr_is(addr, `OFF_EVT_CLEAR))
        evt_clr = wr_data[`EVT_W-1:0];
      else if (addr_is(addr, `OFF_EVT_ENABLE))
        evt_en_we = 1'b1;
      // status registers ignore writes; flag the attempt
      if (!is_writable(addr))
        bad_write = 1'b1;
      // software should keep the upper bits zero
      if (is_writable(addr) && (wr_data[`DATA_W-1:`NUM_CHAN] != `PAD_ZERO))
        rsvd_write = 1'b1;
    end
  end

  // raw terminal-count flags, set by the engine and cleared by software
  irq_flag_bank #(
    .WIDTH(`NUM_CHAN)
  ) u_tc_raw (
    .mclk(mclk),
    .rst_n(rst_n),
    .set(tc_event),
    .clr(tc_irq_clear_bit),
    .flag(tc_raw_bit)
  );

  // raw error flags
  irq_flag_bank #(
    .WIDTH(`NUM_CHAN)
  ) u_err_raw (
    .mclk(mclk),
    .rst_n(rst_n),
    .set(err_event),
    .clr(err_irq_clear_bit),
    .flag(err_raw_bit)
  );

  // masked and combined views; masking never touches the raw flags
  assign tc_masked_status_reg = tc_raw_bit & tc_irq_en;
  assign err_masked_status = err_raw_bit & err_irq_en;
  assign combined_status = tc_masked_status_reg | err_masked_status;

  // request outputs registered, one cycle behind the flags
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      channel_irq_combined <= `CHAN_RESET;
      tc_irq_masked_bit <= `CHAN_RESET;
      err_irq_masked_bit <= `CHAN_RESET;
    end
    else
    begin
      channel_irq_combined <= combined_status;
      tc_irq_masked_bit <= tc_masked_status_reg;
      err_irq_masked_bit <= err_masked_status;
    end
  end

  // block events for the summary interrupt
  always @*
  begin
    evt_d = `EVT_RESET;
    evt_d[`EVT_TC] = |(tc_event & tc_irq_en);
    evt_d[`EVT_ERR] = |(err_event & err_irq_en);
    evt_d[`EVT_BAD_WRITE] = bad_write;
    evt_d[`EVT_RSVD_WRITE] = rsvd_write;
  end

  irq_event_unit u_evt (
    .mclk(mclk),
    .rst_n(rst_n),
    .evt(evt_d),
    .evt_clr(evt_clr),
    .en_we(evt_en_we),
    .en_wdata(wr_data[`EVT_W-1:0]),
    .evt_status(evt_status),
    .evt_enable(evt_enable),
    .irq(irq)
  );

  // read select; undefined upper bits and write-only offsets read zero
  always @*
  begin
    rd_sel_d = `CHAN_RESET;
    rd_data_d = `RDATA_RESET;
    if (rd_en)
    begin
      if (addr_is(addr, `OFF_COMBINED_STATUS))
        rd_sel_d = combined_status;
      else if (addr_is(addr, `OFF_TC_MASKED_STATUS))
        rd_sel_d = tc_masked_status_reg;
      else if (addr_is(addr, `OFF_ERR_MASKED_STATUS))
        rd_sel_d = err_masked_status;
      else if (addr_is(addr, `OFF_TC_RAW_STATUS))
        rd_sel_d = tc_raw_bit;
      else if (addr_is(addr, `OFF_ERR_RAW_STATUS))
        rd_sel_d = err_raw_bit;
      else if (addr_is(addr, `OFF_EVT_STATUS))
        rd_data_d[`EVT_W-1:0] = evt_status;
      else if (addr_is(addr, `OFF_EVT_ENABLE))
        rd_data_d[`EVT_W-1:0] = evt_enable;
      rd_data_d[`NUM_CHAN-1:0] = rd_data_d[`NUM_CHAN-1:0] | rd_sel_d;
    end
  end

  // read data valid only in the cycle after the strobe, zero otherwise
  always @(posedge mclk)
  begin
    if (!rst_n)
      rd_data <= `RDATA_RESET;
    else
      rd_data <= rd_data_d;
  end

endmodule

// file: rtl/irq_event_unit.v
// sticky event status with enable mask and one level interrupt line
`include "dma_irq_defs.vh"

module irq_event_unit (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // event pulses
  input wire [`EVT_W-1:0] evt,
  // software clear bits, one cycle
  input wire [`EVT_W-1:0] evt_clr,
  // enable write
  input wire en_we,
  input wire [`EVT_W-1:0] en_wdata,
  // state
  output wire [`EVT_W-1:0] evt_status,
  output wire [`EVT_W-1:0] evt_enable,
  output reg irq
);

  reg [`EVT_W-1:0] en_q;

  // sticky status, set wins over clear
  irq_flag_bank #(
    .WIDTH(`EVT_W)
  ) u_status (
    .mclk(mclk),
    .rst_n(rst_n),
    .set(evt),
    .clr(evt_clr),
    .flag(evt_status)
  );

  // enable register
  always @(posedge mclk)
  begin
    if (!rst_n)
      en_q <= `EVT_RESET;
    else if (en_we)
      en_q <= en_wdata;
  end

  // level interrupt, registered so the pin never glitches
  always @(posedge mclk)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(evt_status & en_q);
  end

  assign evt_enable = en_q;

endmodule

// file: rtl/irq_flag_bank.v
// bank of sticky flags, set wins over clear
module irq_flag_bank #(
  parameter WIDTH = 8
) (
  // clock and reset
  input wire mclk,
  input wire rst_n,
  // per bit set and clear
  input wire [WIDTH-1:0] set,
  input wire [WIDTH-1:0] clr,
  // flag state
  output wire [WIDTH-1:0] flag
);

  reg [WIDTH-1:0] flag_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : g_bit
      // set beats a clear in the same cycle so no event is lost
      always @(posedge mclk)
      begin
        if (!rst_n)
          flag_q[i] <= 1'b0;
        else if (set[i])
          flag_q[i] <= 1'b1;
        else if (clr[i])
          flag_q[i] <= 1'b0;
      end
    end
  endgenerate

  assign flag = flag_q;

endmodule

// file: verif/dma_irq_asserts.sv
// assertion checker for the dma interrupt status and clear slice
module dma_irq_asserts (
  // clock and reset
  input logic mclk,
  input logic rst_n,
  // register port
  input logic [7:0] addr,
  input logic [31:0] wr_data,
  input logic wr_en,
  input logic rd_en,
  input logic [31:0] rd_data,
  // events and masks
  input logic [7:0] tc_event,
  input logic [7:0] err_event,
  input logic [7:0] tc_irq_en,
  input logic [7:0] err_irq_en,
  // requests
  input logic [7:0] channel_irq_combined,
  input logic [7:0] tc_irq_masked_bit,
  input logic [7:0] err_irq_masked_bit,
  input logic irq
);
  // enabled hits as nets, so $past sees a plain signal
  wire [7:0] tc_hit = tc_event & tc_irq_en;
  wire [7:0] err_hit = err_event & err_irq_en;
  wire [7:0] clr_bits = wr_data[7:0];
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // an event needs two edges: raw flag first, then the request register
  chk_tc_sets:
    assert property (tc_hit != 8'h00 |-> ##2 (tc_irq_masked_bit & $past(tc_hit, 2)) == $past(tc_hit, 2))
    else $error("tc request missing after enabled event");
  chk_err_sets:
    assert property (err_hit != 8'h00 |-> ##2 (err_irq_masked_bit & $past(err_hit, 2)) == $past(err_hit, 2))
    else $error("err request missing after enabled event");
  chk_comb_merge:
    assert property (channel_irq_combined == (tc_irq_masked_bit | err_irq_masked_bit))
    else $error("combined request differs from merged sources");
  chk_mask_only:
    assert property ((tc_irq_masked_bit & ~$past(tc_irq_en)) == 8'h00)
    else $error("tc request on a disabled channel");
  // reset itself is the cause here, so this one is never disabled
  chk_reset_zero:
    assert property (disable iff (1'b0) !rst_n |=> channel_irq_combined == 8'h00 && tc_irq_masked_bit == 8'h00)
    else $error("requests not zero after reset");
  chk_tc_clear:
    assert property (wr_en && addr == 8'h08 && tc_event == 8'h00 |-> ##2 (tc_irq_masked_bit & $past(clr_bits, 2)) == 8'h00)
    else $error("tc request survived a clear");
  chk_wo_read:
    assert property (rd_en && addr == 8'h08 |=> rd_data == 32'h0)
    else $error("write-only clear register read nonzero");
  chk_upper_zero:
    assert property (rd_en |=> rd_data[31:8] == 24'h0)
    else $error("upper read bits not zero");
  // main traffic reached
  cover property (tc_irq_masked_bit != 8'h00);
  cover property (irq);
  cover property (wr_en && addr == 8'h08);
endmodule

bind dma_irq_status_clear dma_irq_asserts i_chk (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .tc_event(tc_event), .err_event(err_event),
  .tc_irq_en(tc_irq_en), .err_irq_en(err_irq_en), .channel_irq_combined(channel_irq_combined),
  .tc_irq_masked_bit(tc_irq_masked_bit), .err_irq_masked_bit(err_irq_masked_bit), .irq(irq));

// file: verif/dma_irq_status_clear_tb.sv
// self-checking bench for the dma interrupt status and clear slice
module dma_irq_status_clear_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
  logic [7:0] addr = 8'h00, tc_event = 8'h00, err_event = 8'h00, tc_irq_en = 8'h00, err_irq_en = 8'h00;
  logic [31:0] wr_data = 32'h0;
  wire [31:0] rd_data;
  wire [7:0] comb, tcm, errm;
  wire irq;
  int num_errors = 0, n_compared = 0, cycles = 0;
  // rows: tc event, err event, tc enable, err enable, expected combined
  logic [7:0] rows [4][5] = '{'{8'h01, 8'h00, 8'hFF, 8'hFF, 8'h01}, '{8'h80, 8'h01, 8'h80, 8'h00, 8'h80},
    '{8'h0F, 8'hF0, 8'h05, 8'h30, 8'h35}, '{8'h00, 8'hFF, 8'h00, 8'hFF, 8'hFF}};

  dma_irq_status_clear i_dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
    .rd_en(rd_en), .rd_data(rd_data), .tc_event(tc_event), .err_event(err_event), .tc_irq_en(tc_irq_en),
    .err_irq_en(err_irq_en), .channel_irq_combined(comb), .tc_irq_masked_bit(tcm),
    .err_irq_masked_bit(errm), .irq(irq));

  always #2 mclk = ~mclk;

  task automatic conclude();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // hang guard, far above the hundred or so cycles needed
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      num_errors++;
      conclude();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask

  // an edge of wait, then one strobe cycle, so the strobe never rises in the edge it fell
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    check("rd_data", rd_data, e);
  endtask

  // requests trail the flags by one edge
  task automatic wait2();
    repeat (2) @(posedge mclk);
    #1;
  endtask

  initial
  begin
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    wait2();
    check("comb", comb, 8'h00);
    check("tcm", tcm, 8'h00);
    rd(8'h08, 32'h0);
    foreach (rows[i])
    begin
      @(posedge mclk);
      tc_irq_en <= rows[i][2];
      err_irq_en <= rows[i][3];
      tc_event <= rows[i][0];
      err_event <= rows[i][1];
      @(posedge mclk);
      tc_event <= 8'h00;
      err_event <= 8'h00;
      wait2();
      check("comb", comb, rows[i][4]);
      check("tcm", tcm, rows[i][0] & rows[i][2]);
      check("errm", errm, rows[i][1] & rows[i][3]);
      rd(8'h00, rows[i][4]);
      rd(8'h14, rows[i][0]);
      rd(8'h0C, rows[i][1] & rows[i][3]);
      wr(8'h08, 32'hFF);
      wr(8'h10, 32'hFF);
      wait2();
      check("comb", comb, 8'h00);
      check("errm", errm, 8'h00);
    end
    // refused writes, zero clears and the summary line
    wr(8'h24, 32'hF);
    wr(8'h28, 32'h4);
    @(posedge mclk);
    tc_irq_en <= 8'hFF;
    tc_event <= 8'h5A;
    @(posedge mclk);
    tc_event <= 8'h00;
    wr(8'h04, 32'hFF);
    wr(8'h08, 32'h0000_FF00);
    wait2();
    check("tcm", tcm, 8'h5A);
    check("irq", irq, 1'b1);
    rd(8'h20, 32'hD);
    rd(8'h04, 32'h5A);
    rd(8'h3C, 32'h0);
    wr(8'h08, 32'h0A);
    wait2();
    check("tcm", tcm, 8'h50);
    wr(8'h28, 32'h0);
    wait2();
    check("irq", irq, 1'b0);
    wr(8'h28, 32'h4);
    wr(8'h24, 32'hF);
    wait2();
    check("irq", irq, 1'b0);
    rd(8'h20, 32'h0);
    // event and clear on one channel in the same cycle: set wins
    @(posedge mclk);
    tc_event <= 8'h01;
    addr <= 8'h08;
    wr_data <= 32'h01;
    wr_en <= 1'b1;
    @(posedge mclk);
    tc_event <= 8'h00;
    wr_en <= 1'b0;
    wait2();
    check("tcm", tcm, 8'h51);
    // reset in mid-run with a flag still set
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    check("tcm", tcm, 8'h00);
    rd(8'h14, 32'h0);
    conclude();
  end
endmodule
